// ---- rtl/ifd_decoder.sv ----
// Purpose: Instruction format and cycle-count decode for the core
// Assumes: One word per IVALID_IN pulse; inputs synchronous to clock
// Notes:   Decode results appear one clock after the last word
//
// What this block does
// - 24-bit word: top 8 bits are the opcode, rest are operands
// - Every instruction falls into one of four classes
// - Only three opcodes take two program words
// - Double-word operands come from both words together
// - Second word of a pair has its top eight bits zero
// - A lone second word executes as a no-operation
// - Plain single-word instructions take one cycle
// - True condition or PC change adds a no-operation cycle
// - Unconditional jumps, indirect jumps, table ops, returns take two or three
// - Taken skip: two cycles over one word, three over two
// - Every double-word instruction takes exactly two cycles
// - Register ops decode base, source and destination registers
// - Memory ops decode address and memory-or-W0 destination
// - Bit ops take target and bit from literal or base register
// - Literal moves decode the literal and its receiver
// - Literal math encodes destination only if not the base
// - Control ops decode program address or table mode
// - Register fields pick one of sixteen registers
`include "ifd_cfg.svh"
module ifd_decoder
  import ifd_pkg::*;
(
  // Clock and reset
  input  wire logic              SYS_CLK_IN,
  input  wire logic              RST_N_IN,
  // Fetched words
  input  wire logic              IVALID_IN,
  input  wire logic [23:0]       IWORD_IN,
  input  wire logic [23:0]       NEXT_WORD_IN,
  input  wire logic              COND_TRUE_IN,
  // Sequencing
  output logic                   DEC_VALID_OUT,
  output logic [7:0]             OPCODE_OUT,
  output ifd_pkg::ifd_class_t    CLASS_OUT,
  output logic                   DOUBLE_OUT,
  output logic [1:0]             CYCLES_OUT,
  output logic                   FLUSH_OUT,
  output logic                   DISCARD_OUT,
  output logic                   SECOND_ERR_OUT,
  // Operands
  output logic [3:0]             BASE_REG_OUT,
  output logic [3:0]             SRC_REG_OUT,
  output logic [1:0]             SRC_MODE_OUT,
  output logic [3:0]             DST_REG_OUT,
  output logic [1:0]             DST_MODE_OUT,
  output logic                   DST_VALID_OUT,
  output logic [12:0]            MEM_ADDR_OUT,
  output logic                   MEM_DST_W0_OUT,
  output logic [3:0]             BIT_SEL_OUT,
  output logic                   BIT_FROM_REG_OUT,
  output logic [15:0]            LIT_OUT,
  output logic [22:0]            PROG_ADDR_OUT,
  output logic [1:0]             TBL_MODE_OUT
);

  // ----------------------------------------------------------------
  // Sequencing state
  // ----------------------------------------------------------------
  ifd_state_t  state_r;
  ifd_state_t  state_nxt;
  logic [23:0] hold_r;
  logic [1:0]  cnt_r;
  logic [1:0]  cnt_nxt;

  wire in_first  = state_r == ST_FIRST;
  wire in_second = state_r == ST_SECOND;
  wire in_flush  = state_r == ST_FLUSH;

  wire [7:0] word_op  = IWORD_IN[`IFD_OP_MSB:`IFD_OP_LSB];
  wire [7:0] next_op  = NEXT_WORD_IN[`IFD_OP_MSB:`IFD_OP_LSB];
  wire take_first     = IVALID_IN & in_first;
  wire dbl_start      = take_first & ifd_is_double(word_op);
  wire emit_single    = take_first & !ifd_is_double(word_op);
  wire emit_double    = IVALID_IN & in_second;
  wire emit           = emit_single | emit_double;
  wire discard        = IVALID_IN & in_flush;
  // The first word of a pair is held while the second arrives
  wire [23:0] dec_word = in_second ? hold_r : IWORD_IN;
  wire [7:0]  dec_op   = dec_word[`IFD_OP_MSB:`IFD_OP_LSB];
  wire ext_bad = emit_double & (word_op != 8'h00);

  // ----------------------------------------------------------------
  // Field split and timing
  // ----------------------------------------------------------------
  ifd_class_t  f_class;
  logic [3:0]  f_base;
  logic [3:0]  f_src;
  logic [1:0]  f_smode;
  logic [3:0]  f_dst;
  logic [1:0]  f_dmode;
  logic        f_dvalid;
  logic [12:0] f_mem;
  logic        f_memw0;
  logic [3:0]  f_bitn;
  logic        f_bitreg;
  logic [15:0] f_lit;
  logic [22:0] f_paddr;
  logic [1:0]  f_tblm;
  logic [1:0]  cyc;
  logic [1:0]  fl_words;

  ifd_field_split u_split (
    .word_in       (dec_word),
    .ext_in        (IWORD_IN),
    .class_out     (f_class),
    .base_out      (f_base),
    .src_out       (f_src),
    .smode_out     (f_smode),
    .dst_out       (f_dst),
    .dmode_out     (f_dmode),
    .dst_valid_out (f_dvalid),
    .mem_out       (f_mem),
    .mem_w0_out    (f_memw0),
    .bitn_out      (f_bitn),
    .bit_reg_out   (f_bitreg),
    .lit_out       (f_lit),
    .paddr_out     (f_paddr),
    .tblm_out      (f_tblm)
  );

  ifd_cycle_count u_cyc (
    .op_in          (dec_op),
    .double_in      (in_second),
    .cond_in        (COND_TRUE_IN),
    .next_double_in (ifd_is_double(next_op)),
    .cycles_out     (cyc),
    .flush_out      (fl_words)
  );

  wire do_flush = emit & (fl_words != 2'h0);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_FIRST: begin
        if (dbl_start) begin
          state_nxt = ST_SECOND;
        end else if (do_flush) begin
          state_nxt = ST_FLUSH;
          cnt_nxt   = fl_words;
        end
      end
      ST_SECOND: begin
        if (do_flush) begin
          state_nxt = ST_FLUSH;
          cnt_nxt   = fl_words;
        end else if (IVALID_IN) begin
          state_nxt = ST_FIRST;
        end
      end
      ST_FLUSH: begin
        if (discard) begin
          cnt_nxt = cnt_r - 2'h1;
          if (cnt_r == 2'h1) begin
            state_nxt = ST_FIRST;
          end
        end
      end
      default: begin
        state_nxt = ST_FIRST;
        cnt_nxt   = 2'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= ST_FIRST;
      cnt_r   <= 2'h0;
      hold_r  <= 24'h000000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (dbl_start) begin
        hold_r <= IWORD_IN;
      end
    end
  end

  // Pulses: one clock after the word that completes or is dropped
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      DEC_VALID_OUT  <= 1'b0;
      FLUSH_OUT      <= 1'b0;
      DISCARD_OUT    <= 1'b0;
      SECOND_ERR_OUT <= 1'b0;
    end else begin
      DEC_VALID_OUT  <= emit;
      FLUSH_OUT      <= do_flush;
      DISCARD_OUT    <= discard;
      SECOND_ERR_OUT <= ext_bad;
    end
  end

  // Decode results hold until the next instruction completes
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      OPCODE_OUT       <= 8'h00;
      CLASS_OUT        <= IFD_CL_CTRL;
      DOUBLE_OUT       <= 1'b0;
      CYCLES_OUT       <= 2'h0;
      BASE_REG_OUT     <= 4'h0;
      SRC_REG_OUT      <= 4'h0;
      SRC_MODE_OUT     <= 2'h0;
      DST_REG_OUT      <= 4'h0;
      DST_MODE_OUT     <= 2'h0;
      DST_VALID_OUT    <= 1'b0;
      MEM_ADDR_OUT     <= 13'h0000;
      MEM_DST_W0_OUT   <= 1'b0;
      BIT_SEL_OUT      <= 4'h0;
      BIT_FROM_REG_OUT <= 1'b0;
      LIT_OUT          <= 16'h0000;
      PROG_ADDR_OUT    <= 23'h000000;
      TBL_MODE_OUT     <= 2'h0;
    end else if (emit) begin
      // A lone second word has opcode zero and so decodes as a no-op
      OPCODE_OUT       <= dec_op;
      CLASS_OUT        <= f_class;
      DOUBLE_OUT       <= in_second;
      CYCLES_OUT       <= cyc;
      BASE_REG_OUT     <= f_base;
      SRC_REG_OUT      <= f_src;
      SRC_MODE_OUT     <= f_smode;
      DST_REG_OUT      <= f_dst;
      DST_MODE_OUT     <= f_dmode;
      DST_VALID_OUT    <= f_dvalid;
      MEM_ADDR_OUT     <= f_mem;
      MEM_DST_W0_OUT   <= f_memw0;
      BIT_SEL_OUT      <= f_bitn;
      BIT_FROM_REG_OUT <= f_bitreg;
      LIT_OUT          <= f_lit;
      PROG_ADDR_OUT    <= f_paddr;
      TBL_MODE_OUT     <= f_tblm;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  property p_opcode_split;
    emit_single |=> DEC_VALID_OUT && !DOUBLE_OUT &&
                    OPCODE_OUT == $past(IWORD_IN[23:16]);
  endproperty
  a_opcode_split: assert property (p_opcode_split)
    else $error("single-word opcode not taken from top byte");

  property p_class;
    emit |=> CLASS_OUT == ifd_class_t'(OPCODE_OUT[7:6]);
  endproperty
  a_class: assert property (p_class)
    else $error("class does not follow opcode");

  property p_three_doubles;
    DEC_VALID_OUT && DOUBLE_OUT |-> OPCODE_OUT inside
      {`IFD_OP_ABSJ, `IFD_OP_CALL2, `IFD_OP_DMOVE};
  endproperty
  a_three_doubles: assert property (p_three_doubles)
    else $error("double-word result for other opcode");

  sequence s_pair;
    dbl_start ##1 IVALID_IN;
  endsequence
  property p_pair_addr;
    s_pair |=> DEC_VALID_OUT && DOUBLE_OUT &&
      PROG_ADDR_OUT == {$past(IWORD_IN[6:0]), hold_r[15:0]};
  endproperty
  a_pair_addr: assert property (p_pair_addr)
    else $error("program address not built from both words");

  property p_ext_zero;
    emit_double && IWORD_IN[23:16] != 8'h00 |=> SECOND_ERR_OUT;
  endproperty
  a_ext_zero: assert property (p_ext_zero)
    else $error("bad second word not flagged");

  property p_lone_nop;
    take_first && word_op == `IFD_OP_NOP |=>
      DEC_VALID_OUT && CYCLES_OUT == 2'h1 && !FLUSH_OUT;
  endproperty
  a_lone_nop: assert property (p_lone_nop)
    else $error("lone second word not a no-op");

  property p_cond_branch;
    take_first && word_op == `IFD_OP_CBR |=>
      CYCLES_OUT == ($past(COND_TRUE_IN) ? 2'h2 : 2'h1);
  endproperty
  a_cond_branch: assert property (p_cond_branch)
    else $error("conditional branch cycle count wrong");

  property p_returns;
    take_first && word_op inside {`IFD_OP_RET, `IFD_OP_IEXIT} |=>
      CYCLES_OUT == 2'h3 && in_flush;
  endproperty
  a_returns: assert property (p_returns)
    else $error("return not three cycles with flush");

  property p_skip;
    take_first && word_op == `IFD_OP_SKIP && COND_TRUE_IN &&
      ifd_is_double(next_op) |=> CYCLES_OUT == 2'h3 && cnt_r == 2'h2;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip over double word miscounted");

  property p_double_two;
    DEC_VALID_OUT && DOUBLE_OUT |-> CYCLES_OUT == 2'h2;
  endproperty
  a_double_two: assert property (p_double_two)
    else $error("double-word instruction not two cycles");

  sequence s_drop;
    FLUSH_OUT && cnt_r == 2'h1 && in_flush && IVALID_IN;
  endsequence
  property p_flush_drop;
    s_drop |=> DISCARD_OUT && !DEC_VALID_OUT;
  endproperty
  a_flush_drop: assert property (p_flush_drop)
    else $error("prefetched word not discarded");

endmodule

// ---- shared/ifd_cfg.svh ----
// Purpose: Encodings, field positions and cycle figures of the decoder
// Assumes: 24-bit instruction words, opcode in the top byte
// Notes:   Definitions only
`ifndef IFD_CFG_SVH
`define IFD_CFG_SVH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define IFD_WORD_W      24
`define IFD_OP_MSB      23
`define IFD_OP_LSB      16
`define IFD_BASE_LSB    12
`define IFD_DST_LSB     8
`define IFD_DMODE_LSB   6
`define IFD_SMODE_LSB   4
`define IFD_SRC_LSB     0
`define IFD_MEM_MSB     12
`define IFD_MEMW0_BIT   13
`define IFD_BITN_LSB    12
`define IFD_LIT_MSB     11
`define IFD_LIT_LSB     4
`define IFD_LIT16_MSB   15
`define IFD_PHI_MSB     6
`define IFD_TBLM_MSB    1

// ----------------------------------------------------------------
// Opcode class bits and sub-form bits
// ----------------------------------------------------------------
`define IFD_CLASS_MSB   7
`define IFD_CLASS_LSB   6
`define IFD_FORM_BIT    5
`define IFD_MEMT_BIT    4

// ----------------------------------------------------------------
// Opcodes with special sequencing
// ----------------------------------------------------------------
`define IFD_OP_NOP      8'h00
`define IFD_OP_CALL2    8'h02
`define IFD_OP_ABSJ     8'h04
`define IFD_OP_UJMP     8'h10
`define IFD_OP_ICALL    8'h11
`define IFD_OP_IJMP     8'h12
`define IFD_OP_TBLRD    8'h13
`define IFD_OP_TBLWR    8'h14
`define IFD_OP_RET      8'h15
`define IFD_OP_IEXIT    8'h16
`define IFD_OP_CBR      8'h18
`define IFD_OP_SKIP     8'h19
`define IFD_OP_DMOVE    8'h5f

// ----------------------------------------------------------------
// Instruction cycle counts
// ----------------------------------------------------------------
`define IFD_CYC_ONE     2'h1
`define IFD_CYC_TWO     2'h2
`define IFD_CYC_THREE   2'h3

`endif

// ---- shared/ifd_pkg.sv ----
// Purpose: Types shared by the decoder modules
// Assumes: ifd_cfg.svh on the include path
// Notes:   Double-word test used by both the sequencer and the timer
`include "ifd_cfg.svh"
package ifd_pkg;

  typedef enum logic [1:0] {
    IFD_CL_CTRL = 2'h0,
    IFD_CL_WB   = 2'h1,
    IFD_CL_BIT  = 2'h2,
    IFD_CL_LIT  = 2'h3
  } ifd_class_t;

  typedef enum logic [2:0] {
    ST_FIRST  = 3'h1,
    ST_SECOND = 3'h2,
    ST_FLUSH  = 3'h4
  } ifd_state_t;

  function automatic logic ifd_is_double(input logic [7:0] op);
    return (op == `IFD_OP_ABSJ) || (op == `IFD_OP_CALL2) ||
           (op == `IFD_OP_DMOVE);
  endfunction

endpackage

// ---- rtl/ifd_field_split.sv ----
// Purpose: Split an instruction into class and operand fields
// Assumes: Combinational; caller registers the results
// Notes:   Unused fields of a class are still driven from the word
`include "ifd_cfg.svh"
module ifd_field_split
  import ifd_pkg::*;
(
  // Instruction words
  input  wire logic [23:0]      word_in,
  input  wire logic [23:0]      ext_in,
  // Decoded fields
  output ifd_pkg::ifd_class_t   class_out,
  output logic      [3:0]       base_out,
  output logic      [3:0]       src_out,
  output logic      [1:0]       smode_out,
  output logic      [3:0]       dst_out,
  output logic      [1:0]       dmode_out,
  output logic                  dst_valid_out,
  output logic      [12:0]      mem_out,
  output logic                  mem_w0_out,
  output logic      [3:0]       bitn_out,
  output logic                  bit_reg_out,
  output logic      [15:0]      lit_out,
  output logic      [22:0]      paddr_out,
  output logic      [1:0]       tblm_out
);

  function automatic logic [3:0] reg_at(input logic [23:0] w,
                                        input int lsb);
    return 4'(w >> lsb);
  endfunction

  wire [7:0] op     = word_in[`IFD_OP_MSB:`IFD_OP_LSB];
  wire       form   = op[`IFD_FORM_BIT];
  wire       is_lit = class_out == IFD_CL_LIT;

  assign class_out   = ifd_class_t'(op[`IFD_CLASS_MSB:`IFD_CLASS_LSB]);
  assign base_out    = reg_at(word_in, `IFD_BASE_LSB);
  assign src_out     = reg_at(word_in, `IFD_SRC_LSB);
  assign dst_out     = reg_at(word_in, `IFD_DST_LSB);
  assign smode_out   = word_in[`IFD_SMODE_LSB+1:`IFD_SMODE_LSB];
  assign dmode_out   = word_in[`IFD_DMODE_LSB+1:`IFD_DMODE_LSB];
  assign mem_out     = word_in[`IFD_MEM_MSB:0];
  assign mem_w0_out  = word_in[`IFD_MEMW0_BIT];
  assign bitn_out    = reg_at(word_in, `IFD_BITN_LSB);
  assign bit_reg_out = (class_out == IFD_CL_BIT) & form;
  // Moves carry a wide literal; arithmetic carries a short one
  assign lit_out     = (is_lit & !form) ?
                       word_in[`IFD_LIT16_MSB:0] :
                       {8'h00, word_in[`IFD_LIT_MSB:`IFD_LIT_LSB]};
  assign dst_valid_out = !(is_lit & form) ||
                         (dst_out != base_out);
  assign paddr_out   = {ext_in[`IFD_PHI_MSB:0],
                        word_in[`IFD_LIT16_MSB:0]};
  assign tblm_out    = word_in[`IFD_TBLM_MSB:0];

endmodule

// ---- rtl/ifd_cycle_count.sv ----
// Purpose: Instruction cycle count and words to discard
// Assumes: cond_in is the conditional test result for this instruction
// Notes:   Table accesses stall without discarding fetched words
`include "ifd_cfg.svh"
module ifd_cycle_count
  import ifd_pkg::*;
(
  // Instruction
  input  wire logic [7:0] op_in,
  input  wire logic       double_in,
  input  wire logic       cond_in,
  input  wire logic       next_double_in,
  // Timing
  output logic      [1:0] cycles_out,
  output logic      [1:0] flush_out
);

  always_comb begin
    cycles_out = `IFD_CYC_ONE;
    flush_out  = 2'h0;
    if (double_in) begin
      cycles_out = `IFD_CYC_TWO;
      if (op_in != `IFD_OP_DMOVE) begin
        flush_out = 2'h1;
      end
    end else begin
      case (op_in)
        `IFD_OP_UJMP, `IFD_OP_ICALL, `IFD_OP_IJMP: begin
          cycles_out = `IFD_CYC_TWO;
          flush_out  = 2'h1;
        end
        `IFD_OP_TBLRD, `IFD_OP_TBLWR: begin
          cycles_out = `IFD_CYC_TWO;
        end
        `IFD_OP_RET, `IFD_OP_IEXIT: begin
          cycles_out = `IFD_CYC_THREE;
          flush_out  = 2'h1;
        end
        `IFD_OP_CBR: begin
          if (cond_in) begin
            cycles_out = `IFD_CYC_TWO;
            flush_out  = 2'h1;
          end
        end
        `IFD_OP_SKIP: begin
          if (cond_in) begin
            // Skipped words are fetched anyway, then thrown away
            cycles_out = next_double_in ? `IFD_CYC_THREE :
                                          `IFD_CYC_TWO;
            flush_out  = next_double_in ? 2'h2 : 2'h1;
          end
        end
        default: begin
          cycles_out = `IFD_CYC_ONE;
        end
      endcase
    end
  end

endmodule

// ---- dv/ifd_fetch_model.sv ----
// Purpose: Program memory fetch path feeding the decoder
// Assumes: Bench pushes {cond, word} entries into q
// Notes:   Idle cycles toggle the word lines; a released bus holds nothing
module ifd_fetch_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Fetch path
  output logic             ivalid_out,
  output logic [23:0]      iword_out,
  output logic [23:0]      next_word_out,
  output logic             cond_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [24:0] q[$];
  int          gap = 0;
  int          wait_n = 0;
  initial begin
    ivalid_out = 1'b0;
    iword_out = 24'h000000;
    next_word_out = 24'h000000;
    cond_out = 1'b0;
  end
  // --------------------------------------------------------------
  // One word per edge, or idle cycles when gap is set
  // --------------------------------------------------------------
  always @(posedge clk_in) begin
    #1;
    if (!rst_n_in) q.delete();
    if (q.size() == 0 || wait_n > 0) begin
      if (wait_n > 0) wait_n--;
      ivalid_out = 1'b0;
      iword_out = ~iword_out;
      next_word_out = ~next_word_out;
      cond_out = ~cond_out;
    end else begin
      {cond_out, iword_out} = q.pop_front();
      next_word_out = (q.size() != 0) ? q[0][23:0] : ~iword_out;
      ivalid_out = 1'b1;
      wait_n = gap;
    end
  end
endmodule

// ---- dv/ifd_decoder_tb.sv ----
// Purpose: Self-checking bench for the instruction decoder
// Assumes: Fetch model supplies words; monitor counts output pulses
// Notes:   Each run() drains the words queued before it, and that run's pulses are judged alone
module ifd_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, iv, ct, dv, dbl, fl, dis, serr, dstv, memw0, bfr;
  logic [23:0] iw, nw;
  logic [22:0] paddr;
  logic [15:0] lit;
  logic [12:0] mem;
  logic [7:0]  op;
  logic [3:0]  base, src, dst, bsel;
  logic [1:0]  cyc, smode, dmode, tblm;
  ifd_pkg::ifd_class_t cls;
  logic [1:0]  cyc_q[$];
  logic        fl_q[$];
  int          n_disc, n_serr;
  int          n_errors = 0;
  int          checks_done = 0;

  initial clk = 1'b0;
  always #10 clk = ~clk;

  ifd_fetch_model ifd_fetch_model_i (.clk_in(clk), .rst_n_in(rst_n),
    .ivalid_out(iv), .iword_out(iw), .next_word_out(nw), .cond_out(ct));

  ifd_decoder ifd_decoder_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .IVALID_IN(iv), .IWORD_IN(iw), .NEXT_WORD_IN(nw), .COND_TRUE_IN(ct),
    .DEC_VALID_OUT(dv), .OPCODE_OUT(op), .CLASS_OUT(cls),
    .DOUBLE_OUT(dbl), .CYCLES_OUT(cyc), .FLUSH_OUT(fl),
    .DISCARD_OUT(dis), .SECOND_ERR_OUT(serr), .BASE_REG_OUT(base),
    .SRC_REG_OUT(src), .SRC_MODE_OUT(smode), .DST_REG_OUT(dst),
    .DST_MODE_OUT(dmode), .DST_VALID_OUT(dstv), .MEM_ADDR_OUT(mem),
    .MEM_DST_W0_OUT(memw0), .BIT_SEL_OUT(bsel),
    .BIT_FROM_REG_OUT(bfr), .LIT_OUT(lit), .PROG_ADDR_OUT(paddr),
    .TBL_MODE_OUT(tblm));

  // --------------------------------------------------------------
  // Monitor: pulses are one cycle, so every edge is looked at
  // --------------------------------------------------------------
  always @(posedge clk) begin
    if (dv === 1'b1) begin
      cyc_q.push_back(cyc);
      fl_q.push_back(fl);
    end
    if (dis === 1'b1) n_disc++;
    if (serr === 1'b1) n_serr++;
  end

  task automatic chk_val(input string nm, input logic [23:0] e,
                         input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_cnt(input string nm, input int e, input int g);
    checks_done++;
    if (g != e) begin
      n_errors++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic put(input logic c, input logic [23:0] w);
    ifd_fetch_model_i.q.push_back({c, w});
  endtask

  // Bounded wait for the model to drain, then let the pulses land
  task automatic run();
    int t;
    cyc_q.delete();
    fl_q.delete();
    n_disc = 0;
    n_serr = 0;
    for (t = 0; t < 100 && ifd_fetch_model_i.q.size() != 0; t++)
      @(posedge clk);
    chk_cnt("drain", 0, ifd_fetch_model_i.q.size());
    repeat (4) @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    chk_val("dec_valid", 0, dv);
    chk_val("cycles", 0, cyc);
    chk_val("class", 0, cls);
    chk_val("opcode", 0, op);
  endtask

  task automatic t_fields();
    logic [7:0]  ops[8] = '{8'h01, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc0,
                            8'he0, 8'he0};
    logic [15:0] lo[8] = '{16'hb5a7, 16'h3c96, 16'h7e21, 16'h9f4b,
                           16'h2d58, 16'hc1e3, 16'h6a0f, 16'h55d2};
    logic [23:0] w;
    logic [1:0]  c;
    for (int i = 0; i < 8; i++) begin
      w = {ops[i], lo[i]};
      c = ops[i][7:6];
      put(1'b0, w);
      run();
      chk_cnt("decodes", 1, cyc_q.size());
      chk_val("cycles", 1, cyc_q[0]);
      chk_val("opcode", ops[i], op);
      chk_val("class", c, cls);
      chk_val("base", w[15:12], base);
      chk_val("src", w[5:0], {smode, src});
      chk_val("dst", w[11:6], {dst, dmode});
      chk_val("mem", w[13:0], {memw0, mem});
      chk_val("bit", {c == 2 && w[21], w[15:12]}, {bfr, bsel});
      chk_val("lit", (c == 3 && !w[21]) ? w[15:0] : {8'h00, w[11:4]},
              lit);
      chk_val("dst_valid", !(c == 3 && w[21] && w[15:12] == w[11:8]),
              dstv);
      chk_val("prog_addr", {w[6:0], w[15:0]}, paddr);
      chk_val("tbl_mode", w[1:0], tblm);
    end
  endtask

  // Gap grows with the index: back to back first, then spaced words
  task automatic t_double();
    logic [7:0] ops[3] = '{8'h02, 8'h04, 8'h5f};
    logic       f;
    for (int i = 0; i < 3; i++) begin
      f = (ops[i] != 8'h5f);
      ifd_fetch_model_i.gap = i;
      put(1'b0, {ops[i], 16'hbeef});
      put(1'b0, 24'h00005a);
      if (f) put(1'b0, 24'h40aaaa);
      run();
      chk_cnt("decodes", 1, cyc_q.size());
      chk_val("double", 1, dbl);
      chk_val("cycles", 2, cyc_q[0]);
      chk_val("flush", f, fl_q[0]);
      chk_cnt("discards", f, n_disc);
      chk_val("prog_addr", {7'h5a, 16'hbeef}, paddr);
      chk_cnt("second_err", 0, n_serr);
    end
    ifd_fetch_model_i.gap = 0;
  endtask

  task automatic t_second();
    put(1'b0, 24'h041234);
    put(1'b0, 24'h120001);
    put(1'b0, 24'h40aaaa);
    run();
    chk_cnt("second_err", 1, n_serr);
    put(1'b0, 24'h000034);
    run();
    chk_val("opcode", 0, op);
    chk_val("double", 0, dbl);
    chk_val("cycles", 1, cyc_q[0]);
    chk_val("flush", 0, fl_q[0]);
  endtask

  task automatic t_cycles();
    logic [7:0] ops[10] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
                            8'h16, 8'h18, 8'h18, 8'h19};
    int cd[10] = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 0};
    int cy[10] = '{2, 2, 2, 2, 2, 3, 3, 2, 1, 1};
    int fe[10] = '{1, 1, 1, 0, 0, 1, 1, 1, 0, 0};
    for (int i = 0; i < 10; i++) begin
      put(cd[i][0], {ops[i], 16'h0000});
      put(1'b0, 24'h400001);
      run();
      chk_cnt("decodes", 2 - fe[i], cyc_q.size());
      chk_val("cycles", cy[i], cyc_q[0]);
      chk_val("flush", fe[i], fl_q[0]);
      chk_cnt("discards", fe[i], n_disc);
    end
  endtask

  task automatic t_skip();
    for (int k = 0; k < 2; k++) begin
      put(1'b1, 24'h190000);
      if (k == 1) begin
        put(1'b0, 24'h04abcd);
        put(1'b0, 24'h000011);
      end else
        put(1'b0, 24'h40bbbb);
      put(1'b0, 24'h40cccc);
      run();
      chk_val("cycles", 2 + k, cyc_q[0]);
      chk_cnt("discards", 1 + k, n_disc);
      chk_cnt("decodes", 2, cyc_q.size());
    end
  endtask

  // Reset between the two words of a pair must drop the half pair
  task automatic t_midreset();
    put(1'b0, 24'h04aaaa);
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    put(1'b0, 24'h40cdef);
    run();
    chk_cnt("decodes", 1, cyc_q.size());
    chk_val("double", 0, dbl);
    chk_val("opcode", 8'h40, op);
  endtask

  initial begin
    #100000;
    n_errors++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    t_reset();
    #1 rst_n = 1'b1;
    @(posedge clk);
    t_fields();
    t_double();
    t_second();
    t_cycles();
    t_skip();
    t_midreset();
    close_out();
  end
endmodule
